// File: hdl/qat_evt.v
// count event and direction decoder for one 16-bit timer
// inputs are already synchronised to aclk; tl_rise/tl_fall are one-cycle
// pulses from hardware toggle-latch changes only
`timescale 1ns/1ps
`default_nettype none
`include "qat_regs.vh"

module qat_evt (
	input wire aclk,
	input wire aresetn,
	input wire [2:0] input_select_field,
	input wire [2:0] timer_mode_field,
	input wire run_bit,
	input wire updown_bit,
	input wire ext_dir_enable,
	input wire cnt_in,
	input wire dir_in,
	input wire tl_rise,
	input wire tl_fall,
	output reg step,
	output reg down,
	output reg trig
);
	reg cnt_q_ff;
	reg dir_q_ff;
	reg [`QAT_PRE_W-1:0] pre_ff;
	wire [`QAT_PRE_W-1:0] pre_mask;
	wire tick;
	wire c_rise;
	wire c_fall;
	wire d_rise;
	wire d_fall;
	wire c_any;
	wire d_any;
	reg edge_sel;

	// free-running prescaler, factor 8 << select
	assign pre_mask = (`QAT_PRE_BASE << input_select_field) - 11'h001;
	assign tick = ((pre_ff & pre_mask) == pre_mask);
	assign c_rise = cnt_in & ~cnt_q_ff;
	assign c_fall = ~cnt_in & cnt_q_ff;
	assign d_rise = dir_in & ~dir_q_ff;
	assign d_fall = ~dir_in & dir_q_ff;
	assign c_any = c_rise | c_fall;
	assign d_any = d_rise | d_fall;

	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q_ff <= 1'b0;
			dir_q_ff <= 1'b0;
			pre_ff <= {`QAT_PRE_W{1'b0}};
		end else begin
			cnt_q_ff <= cnt_in;
			dir_q_ff <= dir_in;
			pre_ff <= pre_ff + 11'h001;
		end
	end

	// counter / reload trigger edge choice; x00 means none
	always @* begin
		case (input_select_field)
		3'h1: edge_sel = c_rise;
		3'h2: edge_sel = c_fall;
		3'h3: edge_sel = c_any;
		3'h5: edge_sel = tl_rise;
		3'h6: edge_sel = tl_fall;
		3'h7: edge_sel = tl_rise | tl_fall;
		default: edge_sel = 1'b0;
		endcase
	end

	always @* begin
		step = 1'b0;
		trig = 1'b0;
		// fixed direction from updown bit, or pin-steered when enabled
		down = ext_dir_enable ? (updown_bit ^ dir_in) : updown_bit;
		case (timer_mode_field)
		`QAT_MODE_TIMER: step = run_bit & tick;
		`QAT_MODE_GATE_LO: step = run_bit & tick & ~cnt_in;
		`QAT_MODE_GATE_HI: step = run_bit & tick & cnt_in;
		`QAT_MODE_COUNTER: step = run_bit & edge_sel;
		`QAT_MODE_RELOAD: trig = edge_sel;
		`QAT_MODE_CAPTURE: begin
			// only the low two select bits matter here
			case (input_select_field[1:0])
			2'h1: trig = c_rise;
			2'h2: trig = c_fall;
			2'h3: trig = c_any;
			default: trig = 1'b0;
			endcase
		end
		`QAT_MODE_INCR: begin
			// a count-pin edge wins if both pins move at once (illegal input)
			if ((input_select_field == 3'h1 || input_select_field == 3'h3)
					&& c_any) begin
				step = run_bit;
				down = c_rise ? dir_in : ~dir_in;
			end else if ((input_select_field == 3'h2 ||
					input_select_field == 3'h3) && d_any) begin
				step = run_bit;
				down = d_rise ? ~cnt_in : cnt_in;
			end
		end
		default: step = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// File: hdl/qat_top.v
// quadrature core timer plus two auxiliary 16-bit timers, axi4-lite slave
// assumes encoder and aux pins are asynchronous; one clock aclk
// Operation
// - count direction follows the order in which the two inputs change
// - count-pin edge: rise down, fall up when direction pin high; reversed low
// - direction-pin edge: rise up, fall down when count pin high; reversed low
// - jitter about one switching point cancels by opposite counts
// - both aux timers identical, with timer, gated, counter, incremental
// - aux timers chain with, reload, or capture the core timer
// - aux control: select 2:0, mode 5:3, run 6, updown 7, dir enable 8
// - mode codes 000 to 110 decoded as listed; 111 reserved, idle
// - a timer counts only while its run bit is one
// - aux timers have no toggle latch and no pin output
// - aux timer and gated modes work like core, without toggle latch
// - aux incremental mode evaluates its own pins like the core
// - aux counter mode counts own pin edges or core latch edges
// - incremental select: 000 stop, 001 count pin, 010 dir pin, 011 both
// - aux counter select 101/110/111: latch rise, fall, either edge
// - only overflow-caused latch changes clock aux timers, not writes
`timescale 1ns/1ps
`default_nettype none
`include "qat_regs.vh"

module qat_top #(
	parameter W = 16
) (
	input wire aclk,
	input wire aresetn,
	input wire [`QAT_ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`QAT_ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire core_count_input,
	input wire core_direction_input,
	input wire aux_a_count_input,
	input wire aux_a_direction_input,
	input wire aux_b_count_input,
	input wire aux_b_direction_input,
	output reg core_toggle_latch
);
	// pin synchronisers: [0] core cnt, [1] core dir, [2..5] aux a/b
	reg [5:0] pin_s1_ff;
	reg [5:0] pin_s2_ff;

	reg [8:0] auxa_ctl_ff;
	reg [8:0] auxb_ctl_ff;
	reg [8:0] core_ctl_ff;
	reg [W-1:0] core_cnt_ff;
	reg [W-1:0] auxa_cnt_ff;
	reg [W-1:0] auxb_cnt_ff;
	reg tl_rise_ff;
	reg tl_fall_ff;

	reg aw_got_ff;
	reg w_got_ff;
	reg [`QAT_ADDR_W-1:0] waddr_ff;
	reg [31:0] wdata_ff;
	reg [3:0] wstrb_ff;

	wire core_step;
	wire core_down;
	wire auxa_step;
	wire auxa_down;
	wire auxa_trig;
	wire auxb_step;
	wire auxb_down;
	wire auxb_trig;
	wire do_wr;
	wire wr_auxa_ctl;
	wire wr_auxb_ctl;
	wire wr_core_ctl;
	wire wr_core_cnt;
	wire wr_auxa_cnt;
	wire wr_auxb_cnt;
	wire wr_hit;
	wire core_wrap;
	wire [15:0] wr_lo;
	wire [15:0] core_ctl_rd;
	wire [15:0] nxt_auxa_ctl;
	wire [15:0] nxt_auxb_ctl;
	wire [15:0] nxt_core_ctl;
	localparam [15:0] CTL_RST = `QAT_CTL_RESET;
	reg [31:0] rd_word;
	reg rd_hit;

	assign do_wr = aw_got_ff & w_got_ff & ~s_axi_bvalid;
	assign wr_auxa_ctl = do_wr & (waddr_ff == `QAT_OFF_AUXA_CTL);
	assign wr_auxb_ctl = do_wr & (waddr_ff == `QAT_OFF_AUXB_CTL);
	assign wr_core_ctl = do_wr & (waddr_ff == `QAT_OFF_CORE_CTL);
	assign wr_core_cnt = do_wr & (waddr_ff == `QAT_OFF_CORE_CNT);
	assign wr_auxa_cnt = do_wr & (waddr_ff == `QAT_OFF_AUXA_CNT);
	assign wr_auxb_cnt = do_wr & (waddr_ff == `QAT_OFF_AUXB_CNT);
	assign wr_hit = wr_auxa_ctl | wr_auxb_ctl | wr_core_ctl |
		wr_core_cnt | wr_auxa_cnt | wr_auxb_cnt |
		(do_wr & (waddr_ff == `QAT_OFF_PINS));

	// byte-lane merge is applied per register against its old value
	assign wr_lo = wdata_ff[15:0];
	assign core_ctl_rd = {6'h00, core_toggle_latch, core_ctl_ff};

	function [15:0] merge;
		input [15:0] old;
		input [15:0] nw;
		input [1:0] strb;
		begin
			merge = {strb[1] ? nw[15:8] : old[15:8],
				strb[0] ? nw[7:0] : old[7:0]};
		end
	endfunction

	assign nxt_auxa_ctl = merge({7'h00, auxa_ctl_ff}, wr_lo,
		wstrb_ff[1:0]) & `QAT_CTL_RW_MASK;
	assign nxt_auxb_ctl = merge({7'h00, auxb_ctl_ff}, wr_lo,
		wstrb_ff[1:0]) & `QAT_CTL_RW_MASK;
	assign nxt_core_ctl = merge({7'h00, core_ctl_ff}, wr_lo,
		wstrb_ff[1:0]) & `QAT_CTL_RW_MASK;

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_ff <= 6'h00;
			pin_s2_ff <= 6'h00;
		end else begin
			pin_s1_ff <= {aux_b_direction_input, aux_b_count_input,
				aux_a_direction_input, aux_a_count_input,
				core_direction_input, core_count_input};
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// core has no latch input of its own; counter select codes 1xx stay idle
	qat_evt u_core (
		.aclk(aclk),
		.aresetn(aresetn),
		.input_select_field(core_ctl_ff[`QAT_SEL_MSB:`QAT_SEL_LSB]),
		.timer_mode_field(core_ctl_ff[`QAT_MODE_MSB:`QAT_MODE_LSB]),
		.run_bit(core_ctl_ff[`QAT_RUN_BIT]),
		.updown_bit(core_ctl_ff[`QAT_UD_BIT]),
		.ext_dir_enable(core_ctl_ff[`QAT_UDE_BIT]),
		.cnt_in(pin_s2_ff[0]),
		.dir_in(pin_s2_ff[1]),
		.tl_rise(1'b0),
		.tl_fall(1'b0),
		.step(core_step),
		.down(core_down),
		.trig()
	);

	qat_evt u_auxa (
		.aclk(aclk),
		.aresetn(aresetn),
		.input_select_field(auxa_ctl_ff[`QAT_SEL_MSB:`QAT_SEL_LSB]),
		.timer_mode_field(auxa_ctl_ff[`QAT_MODE_MSB:`QAT_MODE_LSB]),
		.run_bit(auxa_ctl_ff[`QAT_RUN_BIT]),
		.updown_bit(auxa_ctl_ff[`QAT_UD_BIT]),
		.ext_dir_enable(auxa_ctl_ff[`QAT_UDE_BIT]),
		.cnt_in(pin_s2_ff[2]),
		.dir_in(pin_s2_ff[3]),
		.tl_rise(tl_rise_ff),
		.tl_fall(tl_fall_ff),
		.step(auxa_step),
		.down(auxa_down),
		.trig(auxa_trig)
	);

	qat_evt u_auxb (
		.aclk(aclk),
		.aresetn(aresetn),
		.input_select_field(auxb_ctl_ff[`QAT_SEL_MSB:`QAT_SEL_LSB]),
		.timer_mode_field(auxb_ctl_ff[`QAT_MODE_MSB:`QAT_MODE_LSB]),
		.run_bit(auxb_ctl_ff[`QAT_RUN_BIT]),
		.updown_bit(auxb_ctl_ff[`QAT_UD_BIT]),
		.ext_dir_enable(auxb_ctl_ff[`QAT_UDE_BIT]),
		.cnt_in(pin_s2_ff[4]),
		.dir_in(pin_s2_ff[5]),
		.tl_rise(tl_rise_ff),
		.tl_fall(tl_fall_ff),
		.step(auxb_step),
		.down(auxb_down),
		.trig(auxb_trig)
	);

	// overflow or underflow of the core count
	assign core_wrap = core_step &
		(core_down ? (core_cnt_ff == {W{1'b0}}) : (core_cnt_ff == {W{1'b1}}));

	// core count: software write, then reload (b beats a), then step
	always @(posedge aclk) begin
		if (!aresetn) begin
			core_cnt_ff <= `QAT_CNT_RESET;
		end else if (wr_core_cnt) begin
			core_cnt_ff <= merge(core_cnt_ff, wr_lo, wstrb_ff[1:0]);
		end else if (auxb_trig &&
				auxb_ctl_ff[`QAT_MODE_MSB:`QAT_MODE_LSB] == `QAT_MODE_RELOAD) begin
			core_cnt_ff <= auxb_cnt_ff;
		end else if (auxa_trig &&
				auxa_ctl_ff[`QAT_MODE_MSB:`QAT_MODE_LSB] == `QAT_MODE_RELOAD) begin
			core_cnt_ff <= auxa_cnt_ff;
		end else if (core_step) begin
			core_cnt_ff <= core_down ? core_cnt_ff - 16'h0001 :
				core_cnt_ff + 16'h0001;
		end
	end

	// toggle latch; only hardware toggles raise the chaining pulses
	always @(posedge aclk) begin
		if (!aresetn) begin
			core_toggle_latch <= 1'b0;
			tl_rise_ff <= 1'b0;
			tl_fall_ff <= 1'b0;
		end else begin
			tl_rise_ff <= core_wrap & ~core_toggle_latch;
			tl_fall_ff <= core_wrap & core_toggle_latch;
			if (core_wrap) begin
				core_toggle_latch <= ~core_toggle_latch;
			end else if (wr_core_ctl && wstrb_ff[1]) begin
				core_toggle_latch <= wr_lo[`QAT_TL_BIT];
			end
		end
	end

	// aux counts: software write, then capture, then step
	always @(posedge aclk) begin
		if (!aresetn) begin
			auxa_cnt_ff <= `QAT_CNT_RESET;
			auxb_cnt_ff <= `QAT_CNT_RESET;
		end else begin
			if (wr_auxa_cnt) begin
				auxa_cnt_ff <= merge(auxa_cnt_ff, wr_lo, wstrb_ff[1:0]);
			end else if (auxa_trig && auxa_ctl_ff[`QAT_MODE_MSB:`QAT_MODE_LSB]
					== `QAT_MODE_CAPTURE) begin
				auxa_cnt_ff <= core_cnt_ff;
			end else if (auxa_step) begin
				auxa_cnt_ff <= auxa_down ? auxa_cnt_ff - 16'h0001 :
					auxa_cnt_ff + 16'h0001;
			end
			if (wr_auxb_cnt) begin
				auxb_cnt_ff <= merge(auxb_cnt_ff, wr_lo, wstrb_ff[1:0]);
			end else if (auxb_trig && auxb_ctl_ff[`QAT_MODE_MSB:`QAT_MODE_LSB]
					== `QAT_MODE_CAPTURE) begin
				auxb_cnt_ff <= core_cnt_ff;
			end else if (auxb_step) begin
				auxb_cnt_ff <= auxb_down ? auxb_cnt_ff - 16'h0001 :
					auxb_cnt_ff + 16'h0001;
			end
		end
	end

	// control registers; bits 15..9 of aux controls do not exist
	always @(posedge aclk) begin
		if (!aresetn) begin
			auxa_ctl_ff <= CTL_RST[8:0];
			auxb_ctl_ff <= CTL_RST[8:0];
			core_ctl_ff <= CTL_RST[8:0];
		end else begin
			if (wr_auxa_ctl) begin
				auxa_ctl_ff <= nxt_auxa_ctl[8:0];
			end
			if (wr_auxb_ctl) begin
				auxb_ctl_ff <= nxt_auxb_ctl[8:0];
			end
			if (wr_core_ctl) begin
				core_ctl_ff <= nxt_core_ctl[8:0];
			end
		end
	end

	// write channel: address and data taken in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			waddr_ff <= {`QAT_ADDR_W{1'b0}};
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `QAT_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				waddr_ff <= s_axi_awaddr;
				aw_got_ff <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
				w_got_ff <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_wr) begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `QAT_RESP_OKAY : `QAT_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always @* begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
		`QAT_OFF_AUXA_CTL: rd_word = {23'h000000, auxa_ctl_ff};
		`QAT_OFF_AUXB_CTL: rd_word = {23'h000000, auxb_ctl_ff};
		`QAT_OFF_CORE_CTL: rd_word = {16'h0000, core_ctl_rd};
		`QAT_OFF_CORE_CNT: rd_word = {16'h0000, core_cnt_ff};
		`QAT_OFF_AUXA_CNT: rd_word = {16'h0000, auxa_cnt_ff};
		`QAT_OFF_AUXB_CNT: rd_word = {16'h0000, auxb_cnt_ff};
		`QAT_OFF_PINS: rd_word = {26'h0000000, pin_s2_ff};
		default: begin
			rd_word = 32'h00000000;
			rd_hit = 1'b0;
		end
		endcase
	end

	// read channel: data one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `QAT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? `QAT_RESP_OKAY : `QAT_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: include/qat_regs.vh
// register map, field layout and codes of the quadrature/aux timer unit
// assumes a 32-bit axi4-lite slave with one aligned word per register
`ifndef QAT_REGS_VH
`define QAT_REGS_VH

`define QAT_ADDR_W 16
`define QAT_OFF_AUXA_CTL 16'hFF40
`define QAT_OFF_AUXB_CTL 16'hFF44
`define QAT_OFF_CORE_CTL 16'hFF48
`define QAT_OFF_CORE_CNT 16'hFF4C
`define QAT_OFF_AUXA_CNT 16'hFF50
`define QAT_OFF_AUXB_CNT 16'hFF54
`define QAT_OFF_PINS 16'hFF58

`define QAT_CTL_RESET 16'h0000
`define QAT_CNT_RESET 16'h0000
`define QAT_CTL_RW_MASK 16'h01FF
`define QAT_CORE_RW_MASK 16'h03FF

// control field positions, common to all three timers; bit 9, the toggle latch, is core only
`define QAT_SEL_LSB 0
`define QAT_SEL_MSB 2
`define QAT_MODE_LSB 3
`define QAT_MODE_MSB 5
`define QAT_RUN_BIT 6
`define QAT_UD_BIT 7
`define QAT_UDE_BIT 8
`define QAT_TL_BIT 9

// mode field codes
`define QAT_MODE_TIMER 3'h0
`define QAT_MODE_COUNTER 3'h1
`define QAT_MODE_GATE_LO 3'h2
`define QAT_MODE_GATE_HI 3'h3
`define QAT_MODE_RELOAD 3'h4
`define QAT_MODE_CAPTURE 3'h5
`define QAT_MODE_INCR 3'h6

// smallest prescaler factor, timer input is clk / (base << select)
`define QAT_PRE_BASE 11'h008
`define QAT_PRE_W 11

`define QAT_RESP_OKAY 2'h0
`define QAT_RESP_SLVERR 2'h2

`endif

// File: sim/qat_enc_model.sv
// quadrature encoder model driving one count/direction pin pair
// assumes move() is called from one bench thread right after a clock edge
`timescale 1ns/1ps
`default_nettype none
module qat_enc_model #(
	parameter int hold = 16
) (
	input wire logic aclk,
	output logic pha,
	output logic phb
);
	logic [1:0] pos_ff = 2'h0;
	// gray order: one phase changes per step, a quarter period apart
	assign pha = pos_ff[1] ^ pos_ff[0];
	assign phb = pos_ff[1];
	task automatic move(input int n);
		int k;
		for (k = 0; k < (n < 0 ? -n : n); k++) begin
			@(posedge aclk);
			pos_ff <= n < 0 ? pos_ff - 2'h1 : pos_ff + 2'h1;
			// long hold keeps each input well under the edge rate limit
			repeat (hold) @(posedge aclk);
		end
	endtask
endmodule
`default_nettype wire

// File: sim/qat_top_asserts.sv
// assertions on the bus slave and toggle latch of qat_top
// assumes it is bound to qat_top; reset synchronous, active low
`timescale 1ns/1ps
`default_nettype none
`include "qat_regs.vh"
module qat_top_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`QAT_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic core_toggle_latch
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire logic wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready;
	wire logic rd_take = s_axi_arvalid && s_axi_arready;
	wire logic aux_ctl = s_axi_araddr == `QAT_OFF_AUXA_CTL
		|| s_axi_araddr == `QAT_OFF_AUXB_CTL;
	wire logic mapped = s_axi_araddr >= `QAT_OFF_AUXA_CTL
		&& s_axi_araddr <= `QAT_OFF_PINS && s_axi_araddr[1:0] == 2'h0;
	a_reset_idle: assert property (disable iff (1'h0)
		!aresetn |=> s_axi_awready && s_axi_arready && !s_axi_bvalid
		&& !s_axi_rvalid && !core_toggle_latch)
		else $error("bus not idle after reset");
	a_write_answer: assert property (
		wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer at wrong cycle");
	a_resp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_write_busy: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	a_read_answer: assert property (
		rd_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_read_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped");
	a_read_release: assert property (
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read not released");
	a_unmapped_err: assert property (
		rd_take && !mapped |=> s_axi_rresp == `QAT_RESP_SLVERR
		&& s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	a_aux_unused: assert property (
		rd_take && aux_ctl |=> s_axi_rdata[31:9] == 23'h000000)
		else $error("unused control bits not zero");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_latch: cover property ($rose(core_toggle_latch));
endmodule
bind qat_top qat_top_chk i_chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .core_toggle_latch);
`default_nettype wire

// File: sim/quadrature_aux_timer_unit_tb.sv
// self-checking bench for qat_top: registers, encoder counting, chaining
// assumes qat_enc_model on the core and aux a pins; aux b pins held low
`timescale 1ns/1ps
`default_nettype none
`include "qat_regs.vh"
module quadrature_aux_timer_unit_tb;
	typedef struct {logic [15:0] a; logic [3:0] s;
		logic [31:0] d, e; logic [1:0] r;} qat_row_t;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	// both ready inputs stay high: each answer is taken at its first edge
	logic awv = 1'h0, wv = 1'h0, bry = 1'h1, arv = 1'h0, rry = 1'h1;
	logic [15:0] awa = 16'h0000, ara = 16'h0000;
	logic [31:0] wd = 32'h0000_0000;
	logic [3:0] ws = 4'hF;
	wire logic awr, wrr, bv, arr, rv, tl, ca, cb, aa, ab;
	wire logic [1:0] br, rr;
	wire logic [31:0] rdat;
	int fails = 0;
	int checks = 0;
	int k;
	qat_row_t rows [6] = '{
		'{16'hFF40, 4'hF, 32'hFFFF_FFFF, 32'h0000_01FF, 2'h0},
		'{16'hFF40, 4'h1, 32'h0000_0000, 32'h0000_0100, 2'h0},
		'{16'hFF44, 4'hF, 32'hFFFF_FFFF, 32'h0000_01FF, 2'h0},
		'{16'hFF48, 4'hF, 32'hFFFF_FDFF, 32'h0000_01FF, 2'h0},
		'{16'hFF4C, 4'hF, 32'h0001_2345, 32'h0000_2345, 2'h0},
		'{16'hFF5C, 4'hF, 32'h0000_FFFF, 32'h0000_0000, 2'h2}};
	qat_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wrr), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.core_count_input(ca), .core_direction_input(cb),
		.aux_a_count_input(aa), .aux_a_direction_input(ab),
		.aux_b_count_input(1'h0), .aux_b_direction_input(1'h0),
		.core_toggle_latch(tl));
	qat_enc_model i_enc_c (.aclk(aclk), .pha(ca), .phb(cb));
	qat_enc_model i_enc_a (.aclk(aclk), .pha(aa), .phb(ab));
	initial begin
		forever #2.5 aclk = ~aclk;
	end
	task automatic print_verdict;
		if (fails == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [1:0] r);
		bit done;
		int n;
		done = 0;
		awa <= a;
		ws <= s;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		for (n = 0; n < 50 && !done; n++) begin
			@(posedge aclk);
			if (awv && awr) awv <= 1'h0;
			if (wv && wrr) wv <= 1'h0;
			if (bv) begin
				r = br;
				done = 1;
			end
		end
		if (!done) begin
			fails++;
			print_verdict();
		end
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] d,
		output logic [1:0] r);
		bit done;
		int n;
		done = 0;
		ara <= a;
		arv <= 1'h1;
		for (n = 0; n < 50 && !done; n++) begin
			@(posedge aclk);
			if (arv && arr) arv <= 1'h0;
			if (rv) begin
				d = rdat;
				r = rr;
				done = 1;
			end
		end
		if (!done) begin
			fails++;
			print_verdict();
		end
	endtask
	task automatic wrc(input logic [15:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, 4'hF, d, r);
		cmp("bresp", 32'h0, {30'h0, r});
	endtask
	task automatic rdc(input logic [15:0] a, input logic [31:0] e);
		logic [1:0] r;
		logic [31:0] d;
		rd(a, d, r);
		cmp($sformatf("reg %h", a), e, d);
		cmp("rresp", 32'h0, {30'h0, r});
	endtask
	task automatic rst_chk;
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		for (k = 0; k < 6; k++) rdc(16'hFF40 + 16'(4 * k), 32'h0);
	endtask
	task automatic enc_case(input logic [31:0] c, input int n,
		input logic [31:0] e);
		wrc(`QAT_OFF_CORE_CTL, c);
		i_enc_c.move(n);
		rdc(`QAT_OFF_CORE_CNT, e);
	endtask
	// 24 edges between the two samples hold exactly three /8 prescaler ticks
	task automatic tick_case(input logic [31:0] c, input logic [31:0] e);
		logic [1:0] r;
		logic [31:0] d0;
		logic [31:0] d1;
		wrc(`QAT_OFF_AUXB_CTL, c);
		rd(`QAT_OFF_AUXB_CNT, d0, r);
		repeat (22) @(posedge aclk);
		rd(`QAT_OFF_AUXB_CNT, d1, r);
		cmp("ticks", e, d1 - d0);
	endtask
	initial begin
		logic [1:0] r;
		logic [31:0] d;
		rst_chk();
		for (k = 0; k < 6; k++) begin
			wr(rows[k].a, rows[k].s, rows[k].d, r);
			cmp("bresp", {30'h0, rows[k].r}, {30'h0, r});
			rd(rows[k].a, d, r);
			cmp("rdata", rows[k].e, d);
			cmp("rresp", {30'h0, rows[k].r}, {30'h0, r});
		end
		rst_chk();
		// aux b counts every overflow-caused core latch change, upward
		wrc(`QAT_OFF_AUXB_CTL, 32'h4F);
		enc_case(32'h173, 4, 32'h4);
		enc_case(32'h173, -6, 32'hFFFE);
		cmp("latch", 32'h1, {31'h0, tl});
		rdc(`QAT_OFF_AUXB_CNT, 32'h1);
		wrc(`QAT_OFF_CORE_CTL, 32'h173);
		cmp("latch", 32'h0, {31'h0, tl});
		rdc(`QAT_OFF_AUXB_CNT, 32'h1);
		enc_case(32'h173, 1, 32'hFFFF);
		enc_case(32'h173, -1, 32'hFFFE);
		wrc(`QAT_OFF_CORE_CNT, 32'h100);
		enc_case(32'h171, 4, 32'h102);
		enc_case(32'h171, -4, 32'h100);
		enc_case(32'h172, 4, 32'h102);
		enc_case(32'h172, -4, 32'h100);
		enc_case(32'h170, 4, 32'h100);
		enc_case(32'h133, 4, 32'h100);
		// zero marker handled by software: position cleared by a write
		wrc(`QAT_OFF_CORE_CNT, 32'h0);
		rdc(`QAT_OFF_CORE_CNT, 32'h0);
		wrc(`QAT_OFF_AUXA_CTL, 32'hC9);
		i_enc_a.move(2);
		rdc(`QAT_OFF_AUXA_CNT, 32'hFFFF);
		wrc(`QAT_OFF_AUXA_CTL, 32'h173);
		i_enc_a.move(-3);
		rdc(`QAT_OFF_AUXA_CNT, 32'hFFFC);
		// reload, then capture, each on a rising aux a count pin
		wrc(`QAT_OFF_AUXA_CTL, 32'h21);
		i_enc_a.move(2);
		rdc(`QAT_OFF_CORE_CNT, 32'hFFFC);
		wrc(`QAT_OFF_CORE_CNT, 32'h1234);
		wrc(`QAT_OFF_AUXA_CTL, 32'h29);
		i_enc_a.move(4);
		rdc(`QAT_OFF_AUXA_CNT, 32'h1234);
		for (k = 0; k < 8; k++) begin
			wrc(`QAT_OFF_AUXB_CTL, 32'(k) << 3);
			rdc(`QAT_OFF_AUXB_CTL, 32'(k) << 3);
		end
		// aux b pins are held low: low gate open, high gate shut
		tick_case(32'h40, 32'h3);
		tick_case(32'h50, 32'h3);
		tick_case(32'h58, 32'h0);
		tick_case(32'hC0, 32'hFFFF_FFFD);
		print_verdict();
	end
endmodule
`default_nettype wire
